// ### bpfx_consts.vh
// bpfx_consts.vh: offsets, field positions, reset values and codes for the exec unit
// assumes inclusion by bare name from the design files
`ifndef BPFX_CONSTS_VH
`define BPFX_CONSTS_VH
// register offsets (byte addresses, one word each)
`define BPFX_OFS_CTRL      8'h00
`define BPFX_OFS_STATUS    8'h04
`define BPFX_OFS_AX        8'h08
`define BPFX_OFS_SP        8'h0C
`define BPFX_OFS_CS        8'h10
`define BPFX_OFS_IP        8'h14
`define BPFX_OFS_FLAGS     8'h18
`define BPFX_OFS_INDEX     8'h1C
`define BPFX_OFS_OPND      8'h20
`define BPFX_OFS_TSEG      8'h24
`define BPFX_OFS_TOFS      8'h28
`define BPFX_OFS_RETIP     8'h2C
`define BPFX_OFS_MEM       8'h30
// control word: opcode field and go bit
`define BPFX_CTRL_OP_LSB   0
`define BPFX_CTRL_OP_MSB   2
`define BPFX_CTRL_GO       8
// opcodes
`define BPFX_OP_BOUND      3'h0
`define BPFX_OP_CALL_NEAR  3'h1
`define BPFX_OP_CALL_FAR   3'h2
`define BPFX_OP_SIGN_EXT   3'h3
`define BPFX_OP_CARRY_ZERO 3'h4
`define BPFX_OP_DIR_ZERO   3'h5
`define BPFX_OP_CALL_PTR32 3'h6
// flag bit positions in the flags word
`define BPFX_FLAG_CARRY    0
`define BPFX_FLAG_TRAP     8
`define BPFX_FLAG_IEN      9
`define BPFX_FLAG_DIR      10
// reset values
`define BPFX_RST_SP        16'h0100
`define BPFX_RST_FLAGS     16'h0000
// range trap vector and its type, stack step, sign-extension limit and high-byte fill
`define BPFX_TRAP_TYPE     8'h05
`define BPFX_VEC_IP        8'h1C
`define BPFX_VEC_CS        8'h1E
`define BPFX_STEP          16'h0002
`define BPFX_SIGN_LIMIT    8'h80
`define BPFX_HIGH_ONES     8'hFF
// memory depth in words (word index = byte address >> 1)
`define BPFX_MEM_WORDS     64
`define BPFX_MEM_AW        6
`endif

// ### bpfx_stack_mem.v
// bpfx_stack_mem.v: word memory in flip-flops with one port for the exec unit
// and a second read/write port for software; byte address, low bit ignored
// assumes both ports run on clk_sys and the exec port wins a same-word write
`include "bpfx_consts.vh"
module bpfx_stack_mem (
  input  wire        clk_sys,   // system clock
  input  wire        reset,     // sync reset, active high
  input  wire        x_we,      // exec port write strobe
  input  wire [15:0] x_addr,    // exec port byte address
  input  wire [15:0] x_wdata,   // exec port write word
  output wire [15:0] x_rdata,   // exec port read word (combinational)
  input  wire        s_we,      // software write strobe
  input  wire [15:0] s_addr,    // software byte address
  input  wire [15:0] s_wdata,   // software write word
  output wire [15:0] s_rdata    // software read word (combinational)
);
  reg  [15:0] words [0:`BPFX_MEM_WORDS-1];
  wire [`BPFX_MEM_AW-1:0] x_idx;
  wire [`BPFX_MEM_AW-1:0] s_idx;
  assign x_idx   = x_addr[`BPFX_MEM_AW:1];
  assign s_idx   = s_addr[`BPFX_MEM_AW:1];
  assign x_rdata = words[x_idx];
  assign s_rdata = words[s_idx];
  // one generate entry per word so each word has a single clocked writer
  genvar g;
  generate
    for (g = 0; g < `BPFX_MEM_WORDS; g = g + 1) begin : g_word
      always @(posedge clk_sys) begin
        if (reset) begin
          words[g] <= 16'h0000;
        end else if (x_we && x_idx == g) begin
          words[g] <= x_wdata;
        end else if (s_we && s_idx == g) begin
          words[g] <= s_wdata;
        end
      end
    end
  endgenerate
endmodule // bpfx_stack_mem

// ### bpfx_exec.v
// bpfx_exec.v: executes range check with trap, procedure invoke, byte sign
// extension and the carry/direction clear operations; AHB-Lite register slave
// assumes a single AHB-Lite master on clk_sys, word transfers only
// How it works
// - each flag is kept, made undefined, or updated per instruction
// - range check fails when index below lower or above upper bound
// - lower bound at operand address, upper bound two bytes higher
// - failing check raises trap type 5, otherwise continue without trap
// - trap first lowers stack pointer by 2 and stores flags word
// - after saving flags, trap clears interrupt enable and single-step flags
// - trap pushes code segment, loads new segment from word 1EH
// - trap pushes instruction pointer last, loads new pointer from word 1CH
// - invoke saves return point so exit resumes after the invoke
// - far invoke: push segment, load segment, push pointer, load offset
// - invoke takes near, far, 16-bit pointer and 32-bit memory pointer; here only near, far and 32-bit memory pointer, no 16-bit pointer form
// - sign extension: high byte zero if low byte below 80H, else FFH
// - carry clear zeroes carry only, other flags untouched
// - direction clear zeroes direction so string indices increment
//
// Added by the designer: the AHB-Lite slave port and the placing of the registers.
`include "bpfx_consts.vh"
module bpfx_exec (
  input  wire        clk_sys,    // system clock, 250 MHz
  input  wire        reset,      // sync reset, active high
  input  wire        hsel,       // slave select
  input  wire [31:0] haddr,      // byte address
  input  wire [1:0]  htrans,     // transfer type
  input  wire        hwrite,     // write when high
  input  wire [2:0]  hsize,      // transfer size
  input  wire [31:0] hwdata,     // write data
  input  wire        hready,     // bus ready in
  output wire        hreadyout,  // slave ready, always high
  output wire        hresp,      // always OKAY
  output reg  [31:0] hrdata      // read data, registered
);
  // state codes
  localparam [3:0] ST_IDLE   = 4'h0;
  localparam [3:0] ST_LOWER  = 4'h1;
  localparam [3:0] ST_UPPER  = 4'h2;
  localparam [3:0] ST_PFLAGS = 4'h3;
  localparam [3:0] ST_PCS    = 4'h4;
  localparam [3:0] ST_LCS    = 4'h5;
  localparam [3:0] ST_PIP    = 4'h6;
  localparam [3:0] ST_LIP    = 4'h7;
  localparam [3:0] ST_PTRSEG = 4'h8;
  localparam [3:0] ST_PTROFS = 4'h9;

  // architectural state
  reg [15:0] accum;
  reg [15:0] stack_pointer;
  reg [15:0] code_segment;
  reg [15:0] instruction_pointer;
  reg [15:0] flags;
  reg [15:0] index_reg;
  reg [15:0] opnd_addr;
  reg [15:0] target_segment;
  reg [15:0] target_offset;
  reg [15:0] return_ip;
  reg [2:0]  opcode;
  reg [15:0] lower_bound;
  reg [3:0]  state;
  reg        range_trap;
  reg [7:0]  trap_type;
  reg        busy;

  // memory port
  reg         mem_we;
  reg  [15:0] mem_addr;
  reg  [15:0] mem_wdata;
  wire [15:0] mem_rdata;
  wire [15:0] sw_rdata;

  // ahb address phase capture
  reg        dp_write;
  reg        dp_valid;
  reg [7:0]  dp_addr;
  wire       ap_take;
  wire       sw_mem_we;
  assign ap_take   = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;   // every access completes in one data phase
  assign hresp     = 1'b0;
  assign sw_mem_we = dp_valid && dp_write && dp_addr == `BPFX_OFS_MEM;

  wire go_write;
  assign go_write = dp_valid && dp_write && dp_addr == `BPFX_OFS_CTRL
                    && hwdata[`BPFX_CTRL_GO];

  bpfx_stack_mem i_bpfx_stack_mem (
    .clk_sys (clk_sys),
    .reset   (reset),
    .x_we    (mem_we),
    .x_addr  (mem_addr),
    .x_wdata (mem_wdata),
    .x_rdata (mem_rdata),
    .s_we    (sw_mem_we),
    .s_addr  (hwdata[31:16]),
    .s_wdata (hwdata[15:0]),
    .s_rdata (sw_rdata)
  );

  // signed compare, index against bounds
  wire idx_below;
  wire idx_above;
  assign idx_below = $signed(index_reg) < $signed(lower_bound);
  assign idx_above = $signed(index_reg) > $signed(mem_rdata);

  // memory port steering per state; stack writes use the lowered pointer
  wire [15:0] sp_dec;
  assign sp_dec = stack_pointer - `BPFX_STEP;
  always @* begin
    mem_we    = 1'b0;
    mem_addr  = 16'h0000;
    mem_wdata = 16'h0000;
    case (state)
      ST_LOWER:  mem_addr = opnd_addr;
      ST_UPPER:  mem_addr = opnd_addr + `BPFX_STEP;
      ST_PFLAGS: begin
        mem_we    = 1'b1;
        mem_addr  = sp_dec;
        mem_wdata = flags;
      end
      ST_PCS: begin
        mem_we    = 1'b1;
        mem_addr  = sp_dec;
        mem_wdata = code_segment;
      end
      ST_LCS:    mem_addr = {8'h00, `BPFX_VEC_CS};
      ST_PIP: begin
        mem_we    = 1'b1;
        mem_addr  = sp_dec;
        mem_wdata = return_ip;
      end
      ST_LIP:    mem_addr = {8'h00, `BPFX_VEC_IP};
      ST_PTRSEG: mem_addr = opnd_addr + `BPFX_STEP;
      ST_PTROFS: mem_addr = opnd_addr;
      default:   mem_addr = 16'h0000;
    endcase
  end

  // sequencer and architectural updates; flags not named stay unchanged
  always @(posedge clk_sys) begin
    if (reset) begin
      state               <= ST_IDLE;
      busy                <= 1'b0;
      range_trap          <= 1'b0;
      trap_type           <= 8'h00;
      lower_bound         <= 16'h0000;
      accum               <= 16'h0000;
      stack_pointer       <= `BPFX_RST_SP;
      code_segment        <= 16'h0000;
      instruction_pointer <= 16'h0000;
      flags               <= `BPFX_RST_FLAGS;
      index_reg           <= 16'h0000;
      opnd_addr           <= 16'h0000;
      target_segment      <= 16'h0000;
      target_offset       <= 16'h0000;
      return_ip           <= 16'h0000;
      opcode              <= 3'h0;
    end else begin
      // software writes to operand registers, ignored while busy
      if (dp_valid && dp_write && !busy) begin
        case (dp_addr)
          `BPFX_OFS_AX:    accum               <= hwdata[15:0];
          `BPFX_OFS_SP:    stack_pointer       <= hwdata[15:0];
          `BPFX_OFS_CS:    code_segment        <= hwdata[15:0];
          `BPFX_OFS_IP:    instruction_pointer <= hwdata[15:0];
          `BPFX_OFS_FLAGS: flags               <= hwdata[15:0];
          `BPFX_OFS_INDEX: index_reg           <= hwdata[15:0];
          `BPFX_OFS_OPND:  opnd_addr           <= hwdata[15:0];
          `BPFX_OFS_TSEG:  target_segment      <= hwdata[15:0];
          `BPFX_OFS_TOFS:  target_offset       <= hwdata[15:0];
          `BPFX_OFS_RETIP: return_ip           <= hwdata[15:0];
          default: ;
        endcase
      end
      case (state)
        ST_IDLE: begin
          if (go_write && !busy) begin
            opcode <= hwdata[`BPFX_CTRL_OP_MSB:`BPFX_CTRL_OP_LSB];
            busy   <= 1'b1;
            case (hwdata[`BPFX_CTRL_OP_MSB:`BPFX_CTRL_OP_LSB])
              `BPFX_OP_BOUND: begin
                range_trap <= 1'b0;
                state      <= ST_LOWER;
              end
              `BPFX_OP_CALL_NEAR: begin
                state <= ST_PIP;
              end
              `BPFX_OP_CALL_FAR: begin
                state <= ST_PCS;
              end
              `BPFX_OP_CALL_PTR32: begin
                state <= ST_PTRSEG;
              end
              `BPFX_OP_SIGN_EXT: begin
                // high byte from low byte sign, flags untouched
                accum[15:8] <= (accum[7:0] < `BPFX_SIGN_LIMIT) ? 8'h00
                               : `BPFX_HIGH_ONES;
                busy <= 1'b0;
              end
              `BPFX_OP_CARRY_ZERO: begin
                flags[`BPFX_FLAG_CARRY] <= 1'b0;
                busy <= 1'b0;
              end
              `BPFX_OP_DIR_ZERO: begin
                flags[`BPFX_FLAG_DIR] <= 1'b0;
                busy <= 1'b0;
              end
              default: begin
                busy <= 1'b0;                               // unknown opcode is a no-op
              end
            endcase
          end
        end
        ST_LOWER: begin
          lower_bound <= mem_rdata;
          state       <= ST_UPPER;
        end
        ST_UPPER: begin
          if (idx_below || idx_above) begin
            range_trap <= 1'b1;
            trap_type  <= `BPFX_TRAP_TYPE;
            state      <= ST_PFLAGS;
          end else begin
            state <= ST_IDLE;
            busy  <= 1'b0;
          end
        end
        ST_PFLAGS: begin
          stack_pointer             <= sp_dec;
          flags[`BPFX_FLAG_IEN]     <= 1'b0;
          flags[`BPFX_FLAG_TRAP]    <= 1'b0;
          state                     <= ST_PCS;
        end
        ST_PCS: begin
          stack_pointer <= sp_dec;
          if (opcode == `BPFX_OP_BOUND) begin
            state <= ST_LCS;
          end else begin
            code_segment <= target_segment;
            state        <= ST_PIP;
          end
        end
        ST_LCS: begin
          code_segment <= mem_rdata;
          return_ip    <= instruction_pointer;
          state        <= ST_PIP;
        end
        ST_PIP: begin
          stack_pointer <= sp_dec;
          if (opcode == `BPFX_OP_BOUND) begin
            state <= ST_LIP;
          end else begin
            instruction_pointer <= target_offset;
            state               <= ST_IDLE;
            busy                <= 1'b0;
          end
        end
        ST_LIP: begin
          instruction_pointer <= mem_rdata;
          state               <= ST_IDLE;
          busy                <= 1'b0;
        end
        ST_PTRSEG: begin
          target_segment <= mem_rdata;
          state          <= ST_PTROFS;
        end
        ST_PTROFS: begin
          target_offset <= mem_rdata;
          opcode        <= `BPFX_OP_CALL_FAR;
          state         <= ST_PCS;
        end
        default: begin
          state <= ST_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end

  // ahb data phase bookkeeping
  always @(posedge clk_sys) begin
    if (reset) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
    end else if (hready) begin
      dp_valid <= ap_take;
      dp_write <= hwrite;
      dp_addr  <= haddr[7:0];
    end
  end

  // read data registered at address phase; unmapped reads return zero
  always @(posedge clk_sys) begin
    if (reset) begin
      hrdata <= 32'h00000000;
    end else if (ap_take && !hwrite) begin
      case (haddr[7:0])
        `BPFX_OFS_CTRL:   hrdata <= {23'h000000, busy, 5'h00, opcode};
        `BPFX_OFS_STATUS: hrdata <= {16'h0000, trap_type, 6'h00, range_trap, busy};
        `BPFX_OFS_AX:     hrdata <= {16'h0000, accum};
        `BPFX_OFS_SP:     hrdata <= {16'h0000, stack_pointer};
        `BPFX_OFS_CS:     hrdata <= {16'h0000, code_segment};
        `BPFX_OFS_IP:     hrdata <= {16'h0000, instruction_pointer};
        `BPFX_OFS_FLAGS:  hrdata <= {16'h0000, flags};
        `BPFX_OFS_INDEX:  hrdata <= {16'h0000, index_reg};
        `BPFX_OFS_OPND:   hrdata <= {16'h0000, opnd_addr};
        `BPFX_OFS_TSEG:   hrdata <= {16'h0000, target_segment};
        `BPFX_OFS_TOFS:   hrdata <= {16'h0000, target_offset};
        `BPFX_OFS_RETIP:  hrdata <= {16'h0000, return_ip};
        `BPFX_OFS_MEM:    hrdata <= {16'h0000, sw_rdata};
        default:          hrdata <= 32'h00000000;
      endcase
    end
  end
endmodule // bpfx_exec

// ### bpfx_exec_props.sv
// bpfx_exec_props.sv: port-level assertions for the exec unit register slave
// assumes one AHB-Lite master on clk_sys and the register map of bpfx_consts.vh
`include "bpfx_consts.vh"
module bpfx_exec_props (
  input wire        clk_sys,    // system clock
  input wire        reset,      // sync reset, active high
  input wire        hsel,       // slave select
  input wire [31:0] haddr,      // byte address
  input wire [1:0]  htrans,     // transfer type
  input wire        hwrite,     // write when high
  input wire [31:0] hwdata,     // write data
  input wire        hready,     // bus ready
  input wire        hreadyout,  // slave ready
  input wire        hresp,      // response
  input wire [31:0] hrdata      // read data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  reg       dp_valid;   // a data phase is running
  reg       dp_write;   // that data phase is a write
  reg [7:0] dp_addr;    // its register offset
  reg [3:0] since_go;   // edges since the last start, saturating
  reg       quick_op;   // last start was a one-edge operation
  reg       untouched;  // no write since reset
  wire taken  = hsel & htrans[1] & hready;
  wire rd_end = dp_valid & ~dp_write;
  wire wr_end = dp_valid & dp_write;
  wire go_end = wr_end & (dp_addr == `BPFX_OFS_CTRL) & hwdata[`BPFX_CTRL_GO];
  wire st_rd  = rd_end & (dp_addr == `BPFX_OFS_STATUS);
  // track phases; the counter restarts even on an ignored start, which only widens the window
  always @(posedge clk_sys) begin
    if (reset) begin
      dp_valid  <= 1'b0;
      dp_write  <= 1'b0;
      dp_addr   <= 8'h00;
      since_go  <= 4'hF;
      quick_op  <= 1'b0;
      untouched <= 1'b1;
    end else begin
      dp_valid <= taken;
      dp_write <= hwrite;
      dp_addr  <= haddr[7:0];
      if (go_end) begin
        since_go <= 4'h0;
        quick_op <= (hwdata[2:0] >= 3'h3) && (hwdata[2:0] <= 3'h5);
      end else if (since_go != 4'hF) begin
        since_go <= since_go + 4'h1;
      end
      if (wr_end) begin
        untouched <= 1'b0;
      end
    end
  end
  a_ready_okay: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");
  a_read_pad_zero: assert property (rd_end |-> hrdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_rdata_holds: assert property ($changed(hrdata) |-> rd_end)
    else $error("read data moved without a read");
  a_trap_type_five: assert property (st_rd && hrdata[1] |-> hrdata[15:8] == 8'h05)
    else $error("trap type not five");
  a_busy_bounded: assert property (st_rd && since_go >= 4'hA |-> !hrdata[0])
    else $error("operation still busy too long");
  a_quick_no_busy: assert property (st_rd && quick_op |-> !hrdata[0])
    else $error("one-edge operation seen busy");
  a_sp_reset: assert property (rd_end && dp_addr == `BPFX_OFS_SP && untouched
    |-> hrdata[15:0] == `BPFX_RST_SP) else $error("stack pointer reset value wrong");
  a_flags_reset: assert property (rd_end && dp_addr == `BPFX_OFS_FLAGS && untouched
    |-> hrdata[15:0] == `BPFX_RST_FLAGS) else $error("flags reset value wrong");
  a_ctrl_fields: assert property (rd_end && dp_addr == `BPFX_OFS_CTRL
    |-> hrdata[15:9] == 7'h00 && hrdata[7:3] == 5'h00) else $error("control readback bad");
  a_unmapped_zero: assert property (rd_end && dp_addr >= 8'h34 |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  c_trap: cover property (st_rd && hrdata[1]);
  c_go: cover property (go_end);
  c_quick: cover property (st_rd && quick_op);
endmodule // bpfx_exec_props
bind bpfx_exec bpfx_exec_props i_bpfx_exec_props (.clk_sys(clk_sys), .reset(reset),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

// ### bpfx_exec_tb.sv
// bpfx_exec_tb.sv: self-checking bench driving the exec unit over AHB-Lite
// assumes bpfx_exec and bpfx_stack_mem compile alongside; the bench is the only master
`include "bpfx_consts.vh"
module bpfx_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys  = 1'b0;   // system clock
  logic        reset    = 1'b1;   // sync reset
  logic        hsel     = 1'b0;   // select
  logic [31:0] haddr    = 32'h0;  // address
  logic [1:0]  htrans   = 2'h0;   // transfer type
  logic        hwrite   = 1'b0;   // direction
  logic [31:0] hwdata   = 32'h0;  // write data
  wire         hready;            // slave ready fed back
  wire         hresp;             // response
  wire  [31:0] hrdata;            // read data
  int          n_errors = 0;
  int          checks   = 0;
  logic [31:0] rd;
  logic [7:0]  sx [4] = '{8'h00, 8'h7F, 8'h80, 8'hFF};
  logic [15:0] bx [4] = '{16'hFFFE, 16'h0005, 16'hFFFD, 16'h0006};
  bpfx_exec i_bpfx_exec (.clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata));
  // 4 ns period
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  // one single transfer; read data taken at the edge ending the data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    xfer(1'b1, a, {16'h0, d});
  endtask
  task automatic chk(input logic [7:0] a, input logic [15:0] e);
    xfer(1'b0, a, 32'h0);
    cmp(rd, {16'h0, e});
  endtask
  // memory port: byte address rides in hwdata[31:16] of the data phase
  task automatic mw(input logic [7:0] ma, input logic [15:0] d);
    xfer(1'b1, `BPFX_OFS_MEM, {8'h0, ma, d});
  endtask
  task automatic chkm(input logic [7:0] ma, input logic [15:0] e);
    // the slave picks the word at the read's address phase from the hwdata standing then,
    // so a write to an unmapped offset first leaves the byte address on hwdata
    xfer(1'b1, 8'h44, {8'h0, ma, 16'h0});
    xfer(1'b0, `BPFX_OFS_MEM, {8'h0, ma, 16'h0});
    cmp(rd, {16'h0, e});
  endtask
  // start an operation and poll busy under a bound
  task automatic go(input logic [2:0] op);
    wr(`BPFX_OFS_CTRL, {7'h0, 1'b1, 5'h0, op});
    for (int i = 0; i < 40; i++) begin
      xfer(1'b0, `BPFX_OFS_STATUS, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    cmp({31'h0, rd[0]}, 32'h0);
  endtask
  task automatic setup();
    wr(`BPFX_OFS_SP, 16'h0080);
    wr(`BPFX_OFS_CS, 16'h1111);
    wr(`BPFX_OFS_IP, 16'h2222);
    wr(`BPFX_OFS_FLAGS, 16'h0701);
  endtask
  task automatic inv(input logic [2:0] op, input logic [15:0] ret, cs, ip);
    setup();
    wr(`BPFX_OFS_RETIP, ret);
    go(op);
    if (op == `BPFX_OP_CALL_NEAR) begin
      chk(`BPFX_OFS_SP, 16'h007E);
      chkm(8'h7E, ret);
    end else begin
      chk(`BPFX_OFS_SP, 16'h007C);
      chkm(8'h7E, 16'h1111);
      chkm(8'h7C, ret);
    end
    chk(`BPFX_OFS_CS, cs);
    chk(`BPFX_OFS_IP, ip);
    chk(`BPFX_OFS_FLAGS, 16'h0701);
  endtask
  task automatic end_of_test();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // whole run needs a few hundred cycles; this cuts a hang
  initial begin
    #40000;
    n_errors++;
    end_of_test();
  end
  // main sequence
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    chk(`BPFX_OFS_SP, 16'h0100);
    chk(`BPFX_OFS_FLAGS, 16'h0000);
    chk(8'h44, 16'h0000);
    wr(`BPFX_OFS_FLAGS, 16'h0701);
    foreach (sx[i]) begin
      wr(`BPFX_OFS_AX, {8'h5A, sx[i]});
      go(`BPFX_OP_SIGN_EXT);
      chk(`BPFX_OFS_AX, {sx[i][7] ? 8'hFF : 8'h00, sx[i]});
    end
    chk(`BPFX_OFS_FLAGS, 16'h0701);
    go(`BPFX_OP_CARRY_ZERO);
    chk(`BPFX_OFS_FLAGS, 16'h0700);
    chk(`BPFX_OFS_CTRL, {13'h0, `BPFX_OP_CARRY_ZERO});
    go(`BPFX_OP_DIR_ZERO);
    chk(`BPFX_OFS_FLAGS, 16'h0300);
    // bounds at 40H and 42H, each edge case on both sides
    mw(8'h40, 16'hFFFE);
    mw(8'h42, 16'h0005);
    mw(`BPFX_VEC_IP, 16'h3333);
    mw(`BPFX_VEC_CS, 16'h4444);
    foreach (bx[i]) begin
      setup();
      wr(`BPFX_OFS_INDEX, bx[i]);
      wr(`BPFX_OFS_OPND, 16'h0040);
      go(`BPFX_OP_BOUND);
      if (i < 2) begin
        xfer(1'b0, `BPFX_OFS_STATUS, 32'h0);
        cmp({31'h0, rd[1]}, 32'h0);
        chk(`BPFX_OFS_SP, 16'h0080);
        chk(`BPFX_OFS_IP, 16'h2222);
      end else begin
        chk(`BPFX_OFS_STATUS, {`BPFX_TRAP_TYPE, 8'h02});
        chk(`BPFX_OFS_SP, 16'h007A);
        chkm(8'h7E, 16'h0701);
        chk(`BPFX_OFS_FLAGS, 16'h0401);
        chkm(8'h7C, 16'h1111);
        chk(`BPFX_OFS_CS, 16'h4444);
        chkm(8'h7A, 16'h2222);
        chk(`BPFX_OFS_IP, 16'h3333);
      end
    end
    // invoke forms; the far pointer sits at 50H
    wr(`BPFX_OFS_TSEG, 16'h5555);
    wr(`BPFX_OFS_TOFS, 16'h6666);
    wr(`BPFX_OFS_OPND, 16'h0050);
    mw(8'h50, 16'h0888);
    mw(8'h52, 16'h0999);
    inv(`BPFX_OP_CALL_NEAR, 16'h2BBB, 16'h1111, 16'h6666);
    inv(`BPFX_OP_CALL_FAR, 16'h2AAA, 16'h5555, 16'h6666);
    inv(`BPFX_OP_CALL_PTR32, 16'h2CCC, 16'h0999, 16'h0888);
    end_of_test();
  end
endmodule // bpfx_exec_tb
